// *** core/bfsf_pkg.sv ***
// Shared constants for the buck fault status flag block
package bfsf_pkg;

	// Serial frame layout
	localparam int          FRAME_W      = 24;
	localparam int          CNT_W        = 5;
	localparam logic [4:0]  FRAME_BITS   = 5'h18;
	localparam int          OP_HI        = 23;
	localparam int          OP_LO        = 22;
	localparam int          ADDR_HI      = 21;
	localparam int          ADDR_LO      = 16;
	localparam logic [1:0]  OP_READ      = 2'h0;
	localparam logic [1:0]  OP_RDCLR     = 2'h2;

	// Register addresses
	localparam logic [5:0]  ADDR_THERMAL_ONTIME_STATUS    = 6'h05;
	localparam logic [5:0]  ADDR_PROTECTION_STATUS_SECOND = 6'h06;

	// Thermal and on-time status field positions
	localparam int          TOS_SHORT_CIRC   = 7;
	localparam int          TOS_CH1_OVERHEAT = 5;
	localparam int          TOS_WARN_HIGH    = 4;
	localparam int          TOS_WARN_LOW     = 3;
	localparam int          TOS_SHORT_ON1    = 2;
	localparam int          TOS_SHORT_ON2    = 1;

	// Second protection status field positions
	localparam int          PSS_CH2_OVERHEAT = 23;
	localparam int          PSS_WARN_HIGH    = 22;
	localparam int          PSS_WARN_LOW     = 21;
	localparam int          PSS_LONG_ON1     = 20;
	localparam int          PSS_LONG_ON2     = 19;
	localparam int          PARITY_POS      = 0;

	// Reset values
	localparam logic [23:0] WORD_RESET   = 24'h000000;
	localparam logic [23:0] WORD_UNMAPPED = 24'h000001;

	// Short on-time cycles tolerated before the flag sets
	localparam logic [5:0]  SHORT_LIMIT  = 6'h20;

	// Timing
	localparam int          CLK_PERIOD_NS     = 5;
	localparam int          T_OVT_NS          = 20000;
	localparam int          T_AUTORESTART_NS  = 10000000;
	localparam int          T_TON_MAX_OFF_NS  = 50000;
	localparam int          OVT_CYC   = (T_OVT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          AR_CYC    = T_AUTORESTART_NS / CLK_PERIOD_NS;
	localparam int          PAUSE_CYC = (T_TON_MAX_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          TMR_W     = 24;

	// Long on-time pause states
	typedef enum logic [1:0]
	{
		BFSF_RUN   = 2'h1,
		BFSF_PAUSE = 2'h2
	} bfsf_pause_t;

endpackage

// *** core/bfsf_spi_slave.sv ***
// Serial slave: samples the host clock, shifts frames in and out
`timescale 1ns/1ps
`default_nettype none

module bfsf_spi_slave
(
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic         sck,
	input  wire logic         cs_n,
	input  wire logic         mosi,
	input  wire logic [23:0]  tx_word,
	output var  logic         miso,
	output var  logic         miso_oe,
	output var  logic         frame_valid,
	output var  logic [23:0]  rx_word
);

	logic [2:0]  sck_q;
	logic [2:0]  cs_q;
	logic [1:0]  mosi_q;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_fall;
	logic        cs_rise;
	logic        active;

	logic [23:0] rx_sh_r,  rx_sh_nxt;
	logic [23:0] tx_sh_r,  tx_sh_nxt;
	logic [4:0]  cnt_r,    cnt_nxt;
	logic        miso_r,   miso_nxt;
	logic        oe_r,     oe_nxt;
	logic        fv_r,     fv_nxt;
	logic [23:0] rxw_r,    rxw_nxt;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers, third stage only for edge finding
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			sck_q  <= 3'h0;
			cs_q   <= 3'h7;
			mosi_q <= 2'h0;
		end
		else
		begin
			sck_q  <= {sck_q[1:0], sck};
			cs_q   <= {cs_q[1:0], cs_n};
			mosi_q <= {mosi_q[0], mosi};
		end
	end

	assign sck_rise = sck_q[1] & ~sck_q[2];
	assign sck_fall = ~sck_q[1] & sck_q[2];
	assign cs_fall  = ~cs_q[1] & cs_q[2];
	assign cs_rise  = cs_q[1] & ~cs_q[2];
	assign active   = ~cs_q[1];

	////////////////////////////////////////////////////////////////////////
	// Shift engine: sample on rising edge, present on falling edge
	always_comb
	begin
		rx_sh_nxt = rx_sh_r;
		tx_sh_nxt = tx_sh_r;
		cnt_nxt   = cnt_r;
		miso_nxt  = miso_r;
		oe_nxt    = active;
		fv_nxt    = 1'b0;
		rxw_nxt   = rxw_r;
		if (cs_fall)
		begin
			tx_sh_nxt = tx_word;
			miso_nxt  = tx_word[23];
			cnt_nxt   = 5'h00;
		end
		else if (active && sck_rise)
		begin
			rx_sh_nxt = {rx_sh_r[22:0], mosi_q[1]};
			if (cnt_r != 5'h1f)
				cnt_nxt = cnt_r + 5'h01;
		end
		else if (active && sck_fall)
		begin
			tx_sh_nxt = {tx_sh_r[22:0], 1'b0};
			miso_nxt  = tx_sh_r[22];
		end
		// Frames of any other length are dropped
		if (cs_rise && cnt_r == bfsf_pkg::FRAME_BITS)
		begin
			fv_nxt  = 1'b1;
			rxw_nxt = rx_sh_r;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			rx_sh_r <= bfsf_pkg::WORD_RESET;
			tx_sh_r <= bfsf_pkg::WORD_RESET;
			cnt_r   <= 5'h00;
			miso_r  <= 1'b0;
			oe_r    <= 1'b0;
			fv_r    <= 1'b0;
			rxw_r   <= bfsf_pkg::WORD_RESET;
		end
		else
		begin
			rx_sh_r <= rx_sh_nxt;
			tx_sh_r <= tx_sh_nxt;
			cnt_r   <= cnt_nxt;
			miso_r  <= miso_nxt;
			oe_r    <= oe_nxt;
			fv_r    <= fv_nxt;
			rxw_r   <= rxw_nxt;
		end
	end

	assign miso        = miso_r;
	assign miso_oe     = oe_r;
	assign frame_valid = fv_r;
	assign rx_word     = rxw_r;

endmodule

`default_nettype wire

// *** core/bfsf_chan.sv ***
// One buck channel: overheat latch, short and long on-time protection
`timescale 1ns/1ps
`default_nettype none

module bfsf_chan
#(
	parameter int OVT_CYC   = bfsf_pkg::OVT_CYC,
	parameter int PAUSE_CYC = bfsf_pkg::PAUSE_CYC
)
(
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic hot,
	input  wire logic cool,
	input  wire logic cycle_end,
	input  wire logic short_on,
	input  wire logic at_max,
	input  wire logic clr_ovt,
	input  wire logic clr_short,
	input  wire logic clr_long,
	input  wire logic auto_clr,
	input  wire logic block_ext,
	output var  logic ovt_flag,
	output var  logic short_flag,
	output var  logic long_flag,
	output var  logic short_set,
	output var  logic enable
);

	localparam logic [23:0] OVT_N   = OVT_CYC[23:0];
	localparam logic [23:0] PAUSE_N = PAUSE_CYC[23:0];

	logic [23:0]           hot_cnt_r,   hot_cnt_nxt;
	logic                  ovt_r,       ovt_nxt;
	logic [5:0]            sh_cnt_r,    sh_cnt_nxt;
	logic                  short_r,     short_nxt;
	logic                  prev_max_r,  prev_max_nxt;
	logic                  long_r,      long_nxt;
	bfsf_pkg::bfsf_pause_t mode_r,      mode_nxt;
	logic [23:0]           pause_cnt_r, pause_cnt_nxt;
	logic                  en_r,        en_nxt;
	logic                  ovt_set;
	logic                  sh_set;
	logic                  long_evt;

	always_comb
	begin
		// Overheat filter: hot longer than the filter time
		hot_cnt_nxt = hot ? ((hot_cnt_r == OVT_N) ? hot_cnt_r : hot_cnt_r + 24'h000001) : 24'h000000;
		ovt_set     = (hot && hot_cnt_r == OVT_N) || (auto_clr && !cool);
		if (ovt_set)
			ovt_nxt = 1'b1;
		else if ((clr_ovt && cool) || auto_clr)
			ovt_nxt = 1'b0;
		else
			ovt_nxt = ovt_r;

		// Short on-time cycles counted, consecutive or not
		sh_set     = cycle_end && short_on && sh_cnt_r == bfsf_pkg::SHORT_LIMIT;
		sh_cnt_nxt = sh_cnt_r;
		if (sh_set)
			sh_cnt_nxt = 6'h00;
		else if (cycle_end && short_on)
			sh_cnt_nxt = sh_cnt_r + 6'h01;
		if (sh_set)
			short_nxt = 1'b1;
		else if (clr_short || auto_clr)
			short_nxt = 1'b0;
		else
			short_nxt = short_r;

		// Two consecutive cycles at maximum on-time
		long_evt     = cycle_end && at_max && prev_max_r;
		prev_max_nxt = prev_max_r;
		if (long_evt)
			prev_max_nxt = 1'b0;
		else if (cycle_end)
			prev_max_nxt = at_max;
		if (long_evt)
			long_nxt = 1'b1;
		else if (clr_long || auto_clr)
			long_nxt = 1'b0;
		else
			long_nxt = long_r;

		mode_nxt      = mode_r;
		pause_cnt_nxt = pause_cnt_r;
		case (mode_r)
			bfsf_pkg::BFSF_RUN:
				if (long_evt)
				begin
					mode_nxt      = bfsf_pkg::BFSF_PAUSE;
					pause_cnt_nxt = 24'h000000;
				end
			bfsf_pkg::BFSF_PAUSE:
			begin
				pause_cnt_nxt = pause_cnt_r + 24'h000001;
				if (pause_cnt_r == PAUSE_N - 24'h000001)
					mode_nxt = bfsf_pkg::BFSF_RUN;
			end
			default:
				mode_nxt = bfsf_pkg::BFSF_RUN;
		endcase

		// Channel runs only with no latched overheat or short fault, no external block and no pause; the long flag does not stop it
		en_nxt = !ovt_nxt && !short_nxt && !block_ext && mode_nxt == bfsf_pkg::BFSF_RUN;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			hot_cnt_r   <= 24'h000000;
			ovt_r       <= 1'b0;
			sh_cnt_r    <= 6'h00;
			short_r     <= 1'b0;
			prev_max_r  <= 1'b0;
			long_r      <= 1'b0;
			mode_r      <= bfsf_pkg::BFSF_RUN;
			pause_cnt_r <= 24'h000000;
			en_r        <= 1'b0;
		end
		else
		begin
			hot_cnt_r   <= hot_cnt_nxt;
			ovt_r       <= ovt_nxt;
			sh_cnt_r    <= sh_cnt_nxt;
			short_r     <= short_nxt;
			prev_max_r  <= prev_max_nxt;
			long_r      <= long_nxt;
			mode_r      <= mode_nxt;
			pause_cnt_r <= pause_cnt_nxt;
			en_r        <= en_nxt;
		end
	end

	assign ovt_flag   = ovt_r;
	assign short_flag = short_r;
	assign long_flag  = long_r;
	assign short_set  = sh_set;
	assign enable     = en_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_ovt_needs_cool;
		ovt_r && !cool |=> ovt_r;
	endproperty
	a_ovt_needs_cool: assert property (p_ovt_needs_cool) else $error("overheat flag cleared while hot");

	property p_ovt_off;
		ovt_r |-> !en_r;
	endproperty
	a_ovt_off: assert property (p_ovt_off) else $error("channel enabled with overheat latched");

	property p_short_count;
		cycle_end && short_on && sh_cnt_r == 6'h20 && !short_r |=> short_r && !en_r;
	endproperty
	a_short_count: assert property (p_short_count) else $error("short on-time flag missed");

	property p_short_early;
		sh_cnt_r < 6'h20 && !short_r && !(auto_clr && !cool) |=> !short_r;
	endproperty
	a_short_early: assert property (p_short_early) else $error("short on-time flag set too early");

	property p_long_pause;
		cycle_end && at_max && prev_max_r |=> long_r && !en_r [*2];
	endproperty
	a_long_pause: assert property (p_long_pause) else $error("no pause after long on-time");

endmodule

`default_nettype wire

// *** core/bfsf_status_top.sv ***
// Fault and diagnostic status flags of a dual buck LED driver
//
// Overview of operation
// - In active mode a set channel 1 overheat flag holds channel 1 off, and a read-and-clear only works once cool.
// - In fallback mode each auto-restart tick clears channel 1 overheat, setting it again if not yet cool.
// - Channel 2 overheat sets after heat longer than the filter time and latches until a cool read-and-clear.
// - Channel 1 high warning follows the second warning threshold with hysteresis, read only.
// - Channel 1 low warning follows the first warning threshold with hysteresis, read only.
// - Channel 2 high warning follows the second warning threshold with hysteresis, read only.
// - Channel 2 low warning follows the first warning threshold with hysteresis, read only.
// - Channel 1 short on-time flag sets after more than 32 short cycles, consecutive or not.
// - Channel 1 stays off while its short on-time flag is set; fallback mode clears it each auto-restart tick.
// - Channel 2 short on-time flag sets after more than 32 short cycles and holds channel 2 off until cleared.
// - Two channel 1 cycles at maximum on-time pause channel 1 and latch a flag, cleared in fallback each tick.
// - Two channel 2 cycles at maximum on-time pause channel 2 and latch a flag until read-and-clear.
// - Each returned 24-bit status word carries odd parity in bit 0.
// - The second status register sits at address 0x06 with read-only and read-and-clear fields.
// - Channel 1 short circuit sets when its short on-time flag sets while its average LED voltage is low.
`timescale 1ns/1ps
`default_nettype none

module bfsf_status_top
#(
	parameter int OVT_CYC   = bfsf_pkg::OVT_CYC,
	parameter int AR_CYC    = bfsf_pkg::AR_CYC,
	parameter int PAUSE_CYC = bfsf_pkg::PAUSE_CYC
)
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       spi_sck,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	output var  logic       spi_miso,
	output var  logic       spi_miso_oe,
	input  wire logic [1:0] temp_hot,
	input  wire logic [1:0] temp_cool,
	input  wire logic [1:0] temp_warn_high_on,
	input  wire logic [1:0] temp_warn_high_off,
	input  wire logic [1:0] temp_warn_low_on,
	input  wire logic [1:0] temp_warn_low_off,
	input  wire logic       ch1_vled_low,
	input  wire logic       fallback_operating_mode,
	input  wire logic [1:0] ch_cycle_end,
	input  wire logic [1:0] ch_short_on,
	input  wire logic [1:0] ch_at_max,
	output var  logic [1:0] ch_enable
);

	localparam logic [23:0] AR_N = AR_CYC[23:0];

	// Odd parity over the upper 23 bits
	function automatic logic [23:0] bfsf_with_parity(input logic [23:0] w);
		return {w[23:1], ~(^w[23:1])};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Comparator inputs come from the analog side: two flip-flops
	logic [12:0] ana_q1;
	logic [12:0] ana_q2;

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			ana_q1 <= 13'h0000;
			ana_q2 <= 13'h0000;
		end
		else
		begin
			ana_q1 <= {ch1_vled_low, temp_warn_low_off, temp_warn_low_on, temp_warn_high_off,
				temp_warn_high_on, temp_cool, temp_hot};
			ana_q2 <= ana_q1;
		end
	end

	logic [1:0] hot_s;
	logic [1:0] cool_s;
	logic [1:0] wh_on_s;
	logic [1:0] wh_off_s;
	logic [1:0] wl_on_s;
	logic [1:0] wl_off_s;
	logic       vled_low_s;

	assign hot_s      = ana_q2[1:0];
	assign cool_s     = ana_q2[3:2];
	assign wh_on_s    = ana_q2[5:4];
	assign wh_off_s   = ana_q2[7:6];
	assign wl_on_s    = ana_q2[9:8];
	assign wl_off_s   = ana_q2[11:10];
	assign vled_low_s = ana_q2[12];

	////////////////////////////////////////////////////////////////////////
	// Serial access
	logic [23:0] resp_r, resp_nxt;
	logic        frame_valid;
	logic [23:0] rx_word;

	bfsf_spi_slave u_spi
	(
		.clock       (clock),
		.resetn      (resetn),
		.sck         (spi_sck),
		.cs_n        (spi_cs_n),
		.mosi        (spi_mosi),
		.tx_word     (resp_r),
		.miso        (spi_miso),
		.miso_oe     (spi_miso_oe),
		.frame_valid (frame_valid),
		.rx_word     (rx_word)
	);

	logic [1:0] op;
	logic [5:0] addr;
	logic       rdclr1;
	logic       rdclr2;

	assign op     = rx_word[bfsf_pkg::OP_HI:bfsf_pkg::OP_LO];
	assign addr   = rx_word[bfsf_pkg::ADDR_HI:bfsf_pkg::ADDR_LO];
	assign rdclr1 = frame_valid && op == bfsf_pkg::OP_RDCLR && addr == bfsf_pkg::ADDR_THERMAL_ONTIME_STATUS;
	assign rdclr2 = frame_valid && op == bfsf_pkg::OP_RDCLR && addr == bfsf_pkg::ADDR_PROTECTION_STATUS_SECOND;

	////////////////////////////////////////////////////////////////////////
	// Auto-restart period timer
	logic [23:0] ar_cnt_r, ar_cnt_nxt;
	logic        ar_tick_r, ar_tick_nxt;
	logic        auto_clr1;

	always_comb
	begin
		ar_tick_nxt = (ar_cnt_r == AR_N - 24'h000001);
		ar_cnt_nxt  = ar_tick_nxt ? 24'h000000 : ar_cnt_r + 24'h000001;
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			ar_cnt_r  <= 24'h000000;
			ar_tick_r <= 1'b0;
		end
		else
		begin
			ar_cnt_r  <= ar_cnt_nxt;
			ar_tick_r <= ar_tick_nxt;
		end
	end

	assign auto_clr1 = ar_tick_r && fallback_operating_mode;

	////////////////////////////////////////////////////////////////////////
	// Channels
	logic [1:0] ovt_f;
	logic [1:0] short_f;
	logic [1:0] long_f;
	logic [1:0] short_set;
	logic       sc_r, sc_nxt;

	bfsf_chan #(.OVT_CYC(OVT_CYC), .PAUSE_CYC(PAUSE_CYC)) u_ch1
	(
		.clock      (clock),
		.resetn     (resetn),
		.hot        (hot_s[0]),
		.cool       (cool_s[0]),
		.cycle_end  (ch_cycle_end[0]),
		.short_on   (ch_short_on[0]),
		.at_max     (ch_at_max[0]),
		.clr_ovt    (rdclr1),
		.clr_short  (rdclr1),
		.clr_long   (rdclr2),
		.auto_clr   (auto_clr1),
		.block_ext  (sc_nxt),
		.ovt_flag   (ovt_f[0]),
		.short_flag (short_f[0]),
		.long_flag  (long_f[0]),
		.short_set  (short_set[0]),
		.enable     (ch_enable[0])
	);

	bfsf_chan #(.OVT_CYC(OVT_CYC), .PAUSE_CYC(PAUSE_CYC)) u_ch2
	(
		.clock      (clock),
		.resetn     (resetn),
		.hot        (hot_s[1]),
		.cool       (cool_s[1]),
		.cycle_end  (ch_cycle_end[1]),
		.short_on   (ch_short_on[1]),
		.at_max     (ch_at_max[1]),
		.clr_ovt    (rdclr2),
		.clr_short  (rdclr1),
		.clr_long   (rdclr2),
		.auto_clr   (1'b0),
		.block_ext  (1'b0),
		.ovt_flag   (ovt_f[1]),
		.short_flag (short_f[1]),
		.long_flag  (long_f[1]),
		.short_set  (short_set[1]),
		.enable     (ch_enable[1])
	);

	////////////////////////////////////////////////////////////////////////
	// Short circuit flag and thermal warnings
	logic [1:0] wh_r, wh_nxt;
	logic [1:0] wl_r, wl_nxt;

	always_comb
	begin
		if (short_set[0] && vled_low_s)
			sc_nxt = 1'b1;
		else if (rdclr1 || auto_clr1)
			sc_nxt = 1'b0;
		else
			sc_nxt = sc_r;
		// Real-time bits with hysteresis, no clear by the host
		for (int i = 0; i < 2; i++)
		begin
			wh_nxt[i] = wh_on_s[i] ? 1'b1 : (wh_off_s[i] ? 1'b0 : wh_r[i]);
			wl_nxt[i] = wl_on_s[i] ? 1'b1 : (wl_off_s[i] ? 1'b0 : wl_r[i]);
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			sc_r <= 1'b0;
			wh_r <= 2'h0;
			wl_r <= 2'h0;
		end
		else
		begin
			sc_r <= sc_nxt;
			wh_r <= wh_nxt;
			wl_r <= wl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status words and the answer for the next frame
	logic [23:0] tos_word;
	logic [23:0] pss_word;

	always_comb
	begin
		tos_word = bfsf_pkg::WORD_RESET;
		tos_word[bfsf_pkg::TOS_SHORT_CIRC]   = sc_r;
		tos_word[bfsf_pkg::TOS_CH1_OVERHEAT] = ovt_f[0];
		tos_word[bfsf_pkg::TOS_WARN_HIGH]    = wh_r[0];
		tos_word[bfsf_pkg::TOS_WARN_LOW]     = wl_r[0];
		tos_word[bfsf_pkg::TOS_SHORT_ON1]    = short_f[0];
		tos_word[bfsf_pkg::TOS_SHORT_ON2]    = short_f[1];
		tos_word = bfsf_with_parity(tos_word);
		pss_word = bfsf_pkg::WORD_RESET;
		pss_word[bfsf_pkg::PSS_CH2_OVERHEAT] = ovt_f[1];
		pss_word[bfsf_pkg::PSS_WARN_HIGH]    = wh_r[1];
		pss_word[bfsf_pkg::PSS_WARN_LOW]     = wl_r[1];
		pss_word[bfsf_pkg::PSS_LONG_ON1]     = long_f[0];
		pss_word[bfsf_pkg::PSS_LONG_ON2]     = long_f[1];
		pss_word = bfsf_with_parity(pss_word);
		resp_nxt = resp_r;
		if (frame_valid)
		begin
			if (addr == bfsf_pkg::ADDR_THERMAL_ONTIME_STATUS)
				resp_nxt = tos_word;
			else if (addr == bfsf_pkg::ADDR_PROTECTION_STATUS_SECOND)
				resp_nxt = pss_word;
			else
				resp_nxt = bfsf_pkg::WORD_UNMAPPED;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
			resp_r <= bfsf_pkg::WORD_UNMAPPED;
		else
			resp_r <= resp_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_parity;
		^tos_word && ^pss_word;
	endproperty
	a_parity: assert property (p_parity) else $error("status word parity not odd");

	property p_pss_answer;
		frame_valid && addr == 6'h06 |=> resp_r == $past(pss_word);
	endproperty
	a_pss_answer: assert property (p_pss_answer) else $error("wrong answer for address 0x06");

	property p_warn_high;
		wh_on_s[0] |=> wh_r[0] ##0 tos_word[4];
	endproperty
	a_warn_high: assert property (p_warn_high) else $error("channel 1 high warning not shown");

	property p_warn_low2;
		wl_off_s[1] && !wl_on_s[1] |=> !wl_r[1] && !pss_word[21];
	endproperty
	a_warn_low2: assert property (p_warn_low2) else $error("channel 2 low warning not cleared");

	property p_short_circ;
		short_set[0] && vled_low_s |=> sc_r && !ch_enable[0];
	endproperty
	a_short_circ: assert property (p_short_circ) else $error("short circuit flag not set");

	property p_auto_clr;
		auto_clr1 && cool_s[0] && !(hot_s[0]) |=> !ovt_f[0];
	endproperty
	a_auto_clr: assert property (p_auto_clr) else $error("fallback restart did not clear overheat");

endmodule

`default_nettype wire

// *** verif/bfsf_host.sv ***
// Serial host model: mode 0 frames of 24 bits, MSB first
`timescale 1ns/1ps
`default_nettype none

module bfsf_host
(
	input  wire logic clock,
	output var  logic sck,
	output var  logic cs_n,
	output var  logic mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clock);
	endtask

	// One frame; the answer bit is taken at each sck rise
	task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
		cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			mosi <= tx[i];
			hold(8);
			sck <= 1'b1;
			rx[i] = miso_oe ? miso : 1'bx;
			hold(8);
			sck <= 1'b0;
		end
		hold(8);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		hold(8);
	endtask
endmodule

`default_nettype wire

// *** verif/bfsf_status_top_test.sv ***
// Self-checking bench for the buck fault status flag block
`timescale 1ns/1ps
`default_nettype none

module bfsf_status_top_test;
	localparam int AR = 64;
	localparam logic [5:0] A_TOS = bfsf_pkg::ADDR_THERMAL_ONTIME_STATUS;
	localparam logic [5:0] A_PSS = bfsf_pkg::ADDR_PROTECTION_STATUS_SECOND;
	localparam logic [1:0] RD    = bfsf_pkg::OP_READ;
	localparam logic [1:0] RC    = bfsf_pkg::OP_RDCLR;
	logic       clock, resetn, sck, cs_n, mosi, miso, miso_oe, vled_low, fallback;
	logic [1:0] hot, cool, wh_on, wh_off, wl_on, wl_off, cyc_end, short_on, at_max, en;
	logic [23:0] w;
	int         n_mismatch;
	int         checks;

	bfsf_status_top #(.OVT_CYC(8), .AR_CYC(AR), .PAUSE_CYC(6)) dut_u
	(
		.clock(clock), .resetn(resetn), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
		.spi_miso(miso), .spi_miso_oe(miso_oe), .temp_hot(hot), .temp_cool(cool),
		.temp_warn_high_on(wh_on), .temp_warn_high_off(wh_off), .temp_warn_low_on(wl_on),
		.temp_warn_low_off(wl_off), .ch1_vled_low(vled_low), .fallback_operating_mode(fallback),
		.ch_cycle_end(cyc_end), .ch_short_on(short_on), .ch_at_max(at_max), .ch_enable(en)
	);

	bfsf_host host_u
	(
		.clock(clock), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Enable is looked at just after the edge, once its update has landed
	task automatic chk_en(input logic [1:0] exp);
		#1;
		chk({22'h0, en}, {22'h0, exp});
	endtask

	// Odd parity in bit 0
	function automatic logic [23:0] par(input logic [23:0] d);
		return {d[23:1], ~^d[23:1]};
	endfunction

	// The answer to a frame arrives in the next one
	task automatic acc(input logic [1:0] op, input logic [5:0] a, input logic [23:0] exp);
		wt(1);
		host_u.xfer({op, a, 16'h0000}, w);
		host_u.xfer({bfsf_pkg::OP_READ, a, 16'h0000}, w);
		chk(w, par(exp));
	endtask

	task automatic pulse(input logic [1:0] s, input logic [1:0] m);
		wt(1);
		cyc_end <= 2'h3;
		short_on <= s;
		at_max <= m;
		wt(1);
		cyc_end <= 2'h0;
		short_on <= 2'h0;
		at_max <= 2'h0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_idle();
		chk_en(2'h3);
		acc(RD, A_TOS, 24'h0);
		acc(RD, A_PSS, 24'h0);
		acc(RD, 6'h3f, 24'h0);
	endtask

	task automatic t_warn();
		wt(1);
		wh_on <= 2'h3;
		wl_on <= 2'h3;
		wh_off <= 2'h0;
		wl_off <= 2'h0;
		acc(RC, A_TOS, 24'h18);
		acc(RC, A_PSS, 24'h600000);
		wt(1);
		wh_on <= 2'h0;
		wl_on <= 2'h0;
		acc(RD, A_TOS, 24'h18);
		wt(1);
		wh_off <= 2'h3;
		wl_off <= 2'h3;
		acc(RD, A_TOS, 24'h0);
		acc(RD, A_PSS, 24'h0);
	endtask

	task automatic t_short();
		wt(1);
		vled_low <= 1'b1;
		repeat (32) pulse(2'h3, 2'h0);
		chk_en(2'h3);
		pulse(2'h3, 2'h0);
		wt(2);
		chk_en(2'h0);
		acc(RC, A_TOS, 24'h86);
		chk_en(2'h3);
		acc(RD, A_TOS, 24'h0);
		wt(1);
		vled_low <= 1'b0;
	endtask

	task automatic t_long();
		pulse(2'h0, 2'h3);
		chk_en(2'h3);
		pulse(2'h0, 2'h3);
		wt(2);
		chk_en(2'h0);
		wt(10);
		chk_en(2'h3);
		acc(RC, A_PSS, 24'h180000);
		acc(RD, A_PSS, 24'h0);
	endtask

	task automatic t_hot();
		wt(1);
		hot <= 2'h3;
		cool <= 2'h0;
		wt(16);
		chk_en(2'h0);
		acc(RC, A_TOS, 24'h20);
		acc(RC, A_PSS, 24'h800000);
		acc(RD, A_PSS, 24'h800000);
		wt(1);
		hot <= 2'h0;
		cool <= 2'h3;
		wt(6);
		chk_en(2'h0);
		acc(RC, A_TOS, 24'h20);
		acc(RC, A_PSS, 24'h800000);
		chk_en(2'h3);
	endtask

	task automatic t_fallback();
		wt(1);
		fallback <= 1'b1;
		hot <= 2'h1;
		cool <= 2'h2;
		wt(16);
		chk_en(2'h2);
		wt(2 * AR);
		chk_en(2'h2);
		wt(1);
		hot <= 2'h0;
		cool <= 2'h3;
		wt(AR + 8);
		chk_en(2'h3);
		// Restart ticks clear channel 1 short and long flags only
		repeat (33) pulse(2'h3, 2'h0);
		repeat (2) pulse(2'h0, 2'h3);
		acc(RC, A_TOS, 24'h000002);
		acc(RC, A_PSS, 24'h080000);
		chk_en(2'h3);
		wt(1);
		fallback <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial
	begin
		#150000;
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		n_mismatch = 0;
		checks = 0;
		resetn = 1'b0;
		vled_low = 1'b0;
		fallback = 1'b0;
		hot = 2'h0;
		cool = 2'h3;
		wh_on = 2'h0;
		wl_on = 2'h0;
		wh_off = 2'h3;
		wl_off = 2'h3;
		cyc_end = 2'h0;
		short_on = 2'h0;
		at_max = 2'h0;
		wt(20);
		resetn <= 1'b1;
		wt(3);
		t_idle();
		t_warn();
		t_short();
		t_long();
		t_hot();
		t_fallback();
		stop_test();
	end
endmodule

`default_nettype wire
